// File: hw/sap_pkg.sv
// shared constants and types for the sink auto-negotiation policy block
package sap_pkg;
    // supply type field of a power data object
    localparam int PDO_TYPE_LO = 30;
    localparam logic [1:0] PDO_FIXED = 2'h0;
    localparam logic [1:0] PDO_BATT = 2'h1;
    localparam logic [1:0] PDO_VAR = 2'h2;
    localparam logic [1:0] PDO_AUG = 2'h3;
    localparam int APDO_SUB_LO = 28;
    localparam logic [1:0] APDO_PPS = 2'h0;
    // classic object fields, 10 bits each
    localparam int VMAX_LO = 20;
    localparam int VMIN_LO = 10;
    localparam int CUR_LO = 0;
    // programmable supply fields
    localparam int PPS_VMAX_LO = 17;
    localparam int PPS_VMIN_LO = 8;
    localparam int PPS_CUR_LO = 0;
    // unit scaling: 50 mV x 10 mA = 0.5 mW, divided into 250 mW steps
    localparam int MV_PER_LSB = 50;
    localparam int MW_PER_LSB = 250;
    localparam int PWR_DIV = 500;
    localparam int PPS_V_SCALE = 2;
    localparam int PPS_I_SCALE = 5;
    // preference among equal power objects
    localparam logic [1:0] RANK_FIXED = 2'h3;
    localparam logic [1:0] RANK_VAR = 2'h2;
    localparam logic [1:0] RANK_BATT = 2'h1;
    // configuration bit positions and reset image
    localparam int CFG_TIE_LOWER = 0;
    localparam int CFG_NO_SUSP = 1;
    localparam int CFG_SUPPRESS = 2;
    localparam int CFG_PPS_EN = 3;
    localparam int CFG_AUTO_FLOOR = 4;
    localparam int CFG_AUTO_CEIL = 5;
    localparam int CFG_AUTO_DIS = 6;
    localparam logic [6:0] CFG_RST = 7'h36;
    // request object layout
    localparam int RDO_POS_LO = 28;
    localparam int RDO_MISMATCH = 26;
    localparam int RDO_NO_SUSP = 24;
    localparam int RDO_OP_LO = 10;
    localparam int RDO_MAX_LO = 0;
    localparam logic PATH_RST = 1'h1;
    // scan sequencer states
    typedef enum logic [1:0] {S_IDLE, S_SNK, S_SRC, S_DONE} sap_state_e;
endpackage : sap_pkg

// File: hw/sap_pdo_eval.sv
// decodes one power data object into voltage range, current and power
`timescale 1ns/1ps
module sap_pdo_eval (
    input wire logic [31:0] pdo_i,
    output logic [1:0] kind_o,
    output logic is_pps_o,
    output logic [11:0] power_o,
    output logic [9:0] vmin_o,
    output logic [9:0] vmax_o,
    output logic [9:0] cur_o
);
    logic [19:0] prod;

    // per supply type decode, voltage in 50 mV and current in 10 mA steps
    always_comb begin
        kind_o = pdo_i[sap_pkg::PDO_TYPE_LO +: 2];
        is_pps_o = 1'b0;
        vmax_o = pdo_i[sap_pkg::VMAX_LO +: 10];
        vmin_o = pdo_i[sap_pkg::VMIN_LO +: 10];
        cur_o = pdo_i[sap_pkg::CUR_LO +: 10];
        unique case (kind_o)
            sap_pkg::PDO_FIXED: begin
                vmax_o = pdo_i[sap_pkg::VMIN_LO +: 10];
            end
            sap_pkg::PDO_BATT: begin
                cur_o = 10'h000;
            end
            sap_pkg::PDO_VAR: begin
            end
            sap_pkg::PDO_AUG: begin
                is_pps_o = pdo_i[sap_pkg::APDO_SUB_LO +: 2] == sap_pkg::APDO_PPS;
                vmax_o = 10'(pdo_i[sap_pkg::PPS_VMAX_LO +: 8] * sap_pkg::PPS_V_SCALE);
                vmin_o = 10'(pdo_i[sap_pkg::PPS_VMIN_LO +: 8] * sap_pkg::PPS_V_SCALE);
                cur_o = 10'(pdo_i[sap_pkg::PPS_CUR_LO +: 7] * sap_pkg::PPS_I_SCALE);
                if (!is_pps_o) begin
                    vmax_o = 10'h000;
                    vmin_o = 10'h000;
                    cur_o = 10'h000;
                end
            end
        endcase
        // variable uses max voltage, fixed its single voltage
        prod = 20'(vmax_o) * 20'(cur_o);
        power_o = 12'(prod / 20'(sap_pkg::PWR_DIV));
        if (kind_o == sap_pkg::PDO_BATT) begin
            power_o = {2'h0, pdo_i[sap_pkg::CUR_LO +: 10]}; // operating power
        end
    end
endmodule : sap_pdo_eval

// File: hw/sap_sink_policy.sv
// sink auto-negotiation policy: limits, object selection, mismatch and sink path
// Functional notes
// - With auto-disable set, the sink path turns off whenever a contract raises the mismatch flag, unless a ready task comes in that same cycle.
// - A sink-ready task forces the sink path back on even while a mismatch stands.
// - A later contract that raises the mismatch flag turns the path off again after a ready task.
// - The ceiling select bit picks host (0) or computed (1) maximum voltage and resets to 1.
// - The floor select bit picks host (0) or computed (1) minimum voltage and resets to 1.
// - A mismatch exists when no source object reaches the mismatch power threshold.
// - With PPS enabled, a mismatch also exists when no source PPS object meets the sink PPS need.
// - The request mismatch flag is raised on a mismatch unless the suppression bit is set.
// - With no battery sink object, the required sink power is the largest power of all valid sink capability objects.
// - Object power is operating power, max voltage times current, or voltage times current.
// - If any battery sink object exists, required power is the largest battery power only.
// - The no-suspend bit, reset to 1, is copied into every request sent.
// - Only objects at or below the voltage ceiling (50 mV steps) are selected.
// - Required power is in 250 mW steps and the selection strives to obtain it.
// - Highest power wins, then fixed over variable, then the tie bit picks higher or lower voltage.
`timescale 1ns/1ps
module sap_sink_policy #(
    parameter int N_PDO = 7,
    parameter int CNT_W = $clog2(N_PDO + 1)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_auto_disable_i,
    input wire logic cfg_auto_ceiling_i,
    input wire logic cfg_auto_floor_select_i,
    input wire logic cfg_suppress_cap_mismatch_i,
    input wire logic cfg_no_suspend_flag_i,
    input wire logic cfg_tie_lower_i,
    input wire logic cfg_pps_enable_i,
    input wire logic [9:0] neg_voltage_ceiling_i,
    input wire logic [9:0] neg_voltage_floor_i,
    input wire logic [9:0] mismatch_power_threshold_i,
    input wire logic snk_caps_wr_i,
    input wire logic [N_PDO*32-1:0] transmit_sink_capabilities_i,
    input wire logic [CNT_W-1:0] snk_count_i,
    input wire logic src_caps_i,
    input wire logic [N_PDO*32-1:0] src_caps_pdo_i,
    input wire logic [CNT_W-1:0] src_count_i,
    input wire logic sink_ready_task_i,
    output logic busy_o,
    output logic rdo_valid_o,
    output logic [31:0] rdo_o,
    output logic cap_mismatch_o,
    output logic sink_path_en_o,
    output logic [9:0] sink_required_power_o,
    output logic [9:0] neg_voltage_ceiling_o,
    output logic [9:0] neg_voltage_floor_o
);
    localparam int IDX_W = $clog2(N_PDO);

    typedef struct packed {
        sap_pkg::sap_state_e st;
        logic [IDX_W-1:0] idx;
        logic snk_pend;
        logic src_pend;
        logic [11:0] all_max;
        logic [11:0] bat_max;
        logic have_bat;
        logic [9:0] vmin;
        logic [9:0] vmax;
        logic pps_have;
        logic [9:0] pps_vmin;
        logic [9:0] pps_vmax;
        logic [9:0] pps_cur;
        logic [9:0] req_pwr;
        logic [9:0] auto_ceil;
        logic [9:0] auto_floor;
        logic found;
        logic [IDX_W-1:0] best_idx;
        logic [11:0] best_pwr;
        logic [1:0] best_rank;
        logic [9:0] best_v;
        logic [9:0] best_cur;
        logic thr_hit;
        logic pps_ok;
        logic mism;
        logic flag;
        logic rdo_valid;
        logic [31:0] rdo;
    } sap_scan_s;

    sap_scan_s s_q;
    sap_scan_s s_d;
    logic [6:0] cfg_q;
    logic [6:0] cfg_d;
    logic path_q;
    logic path_d;
    logic [9:0] ceil_q;
    logic [9:0] ceil_d;
    logic [9:0] floor_q;
    logic [9:0] floor_d;
    logic [31:0] e_pdo;
    logic [1:0] e_kind;
    logic e_pps;
    logic [11:0] e_pwr;
    logic [9:0] e_vmin;
    logic [9:0] e_vmax;
    logic [9:0] e_cur;
    logic in_rng;
    logic accept;
    logic better;
    logic [1:0] e_rank;

    function automatic logic [9:0] sat10(input logic [11:0] p);
        sat10 = (p > 12'h3FF) ? 10'h3FF : p[9:0];
    endfunction : sat10

    ////////////////////////////////////////////////////////////////////////////
    // configuration bits, written as a group by the host

    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr_i) begin
            cfg_d[sap_pkg::CFG_TIE_LOWER] = cfg_tie_lower_i;
            cfg_d[sap_pkg::CFG_NO_SUSP] = cfg_no_suspend_flag_i;
            cfg_d[sap_pkg::CFG_SUPPRESS] = cfg_suppress_cap_mismatch_i;
            cfg_d[sap_pkg::CFG_PPS_EN] = cfg_pps_enable_i;
            cfg_d[sap_pkg::CFG_AUTO_FLOOR] = cfg_auto_floor_select_i;
            cfg_d[sap_pkg::CFG_AUTO_CEIL] = cfg_auto_ceiling_i;
            cfg_d[sap_pkg::CFG_AUTO_DIS] = cfg_auto_disable_i; // no interlock with suppress
        end
    end

    // reset image sets ceiling, floor, suppress and no-suspend selects
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= sap_pkg::CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // voltage limits: host value or value derived from the sink scan

    always_comb begin
        ceil_d = cfg_q[sap_pkg::CFG_AUTO_CEIL] ? s_q.auto_ceil : neg_voltage_ceiling_i;
        floor_d = cfg_q[sap_pkg::CFG_AUTO_FLOOR] ? s_q.auto_floor : neg_voltage_floor_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ceil_q <= 10'h000;
            floor_q <= 10'h000;
        end else begin
            ceil_q <= ceil_d;
            floor_q <= floor_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared object evaluator, fed from the list being scanned

    always_comb begin
        if (s_q.st == sap_pkg::S_SNK) begin
            e_pdo = transmit_sink_capabilities_i[32*s_q.idx +: 32];
            in_rng = CNT_W'(s_q.idx) < snk_count_i;
        end else begin
            e_pdo = src_caps_pdo_i[32*s_q.idx +: 32];
            in_rng = CNT_W'(s_q.idx) < src_count_i;
        end
    end

    sap_pdo_eval u_eval (
        .pdo_i(e_pdo),
        .kind_o(e_kind),
        .is_pps_o(e_pps),
        .power_o(e_pwr),
        .vmin_o(e_vmin),
        .vmax_o(e_vmax),
        .cur_o(e_cur)
    );

    // acceptability and ranking of the current source object
    always_comb begin
        unique case (e_kind)
            sap_pkg::PDO_FIXED: e_rank = sap_pkg::RANK_FIXED;
            sap_pkg::PDO_VAR: e_rank = sap_pkg::RANK_VAR;
            sap_pkg::PDO_BATT: e_rank = sap_pkg::RANK_BATT;
            sap_pkg::PDO_AUG: e_rank = 2'h0;
        endcase
        accept = (e_kind != sap_pkg::PDO_AUG) && (e_vmax <= ceil_q) && (e_vmin >= floor_q);
        // highest power first, so the required power is reached whenever offered
        better = !s_q.found || (e_pwr > s_q.best_pwr);
        if (s_q.found && e_pwr == s_q.best_pwr) begin
            if (e_rank != s_q.best_rank) begin
                better = e_rank > s_q.best_rank;
            end else if (cfg_q[sap_pkg::CFG_TIE_LOWER]) begin
                better = e_vmax < s_q.best_v;
            end else begin
                better = e_vmax > s_q.best_v;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan sequencer: sink list for limits, source list for the request

    always_comb begin
        s_d = s_q;
        s_d.rdo_valid = 1'b0;
        unique case (s_q.st)
            sap_pkg::S_IDLE: begin
                if (s_q.snk_pend) begin
                    s_d.st = sap_pkg::S_SNK;
                    s_d.snk_pend = 1'b0;
                    s_d.idx = '0;
                    s_d.all_max = 12'h000;
                    s_d.bat_max = 12'h000;
                    s_d.have_bat = 1'b0;
                    s_d.vmin = 10'h3FF;
                    s_d.vmax = 10'h000;
                    s_d.pps_have = 1'b0;
                end else if (s_q.src_pend) begin
                    s_d.st = sap_pkg::S_SRC;
                    s_d.src_pend = 1'b0;
                    s_d.idx = '0;
                    s_d.found = 1'b0;
                    s_d.best_pwr = 12'h000;
                    s_d.thr_hit = 1'b0;
                    s_d.pps_ok = 1'b0;
                end
            end
            sap_pkg::S_SNK: begin
                if (in_rng) begin
                    if (e_pwr > s_q.all_max) begin
                        s_d.all_max = e_pwr;
                    end
                    if (e_kind == sap_pkg::PDO_BATT) begin
                        s_d.have_bat = 1'b1;
                        if (e_pwr > s_q.bat_max) begin
                            s_d.bat_max = e_pwr;
                        end
                    end
                    if (e_kind != sap_pkg::PDO_AUG) begin
                        if (e_vmin < s_q.vmin) begin
                            s_d.vmin = e_vmin;
                        end
                        if (e_vmax > s_q.vmax) begin
                            s_d.vmax = e_vmax;
                        end
                    end else if (e_pps && !s_q.pps_have) begin
                        s_d.pps_have = 1'b1;
                        s_d.pps_vmin = e_vmin;
                        s_d.pps_vmax = e_vmax;
                        s_d.pps_cur = e_cur;
                    end
                end
                s_d.idx = s_q.idx + 1'b1;
                if (s_q.idx == IDX_W'(N_PDO - 1)) begin
                    s_d.st = sap_pkg::S_IDLE;
                    s_d.req_pwr = sat10(s_d.have_bat ? s_d.bat_max : s_d.all_max);
                    s_d.auto_ceil = s_d.vmax;
                    s_d.auto_floor = (s_d.vmin == 10'h3FF) ? 10'h000 : s_d.vmin;
                end
            end
            sap_pkg::S_SRC: begin
                if (in_rng) begin
                    if (e_pwr >= {2'h0, mismatch_power_threshold_i}) begin
                        s_d.thr_hit = 1'b1;
                    end
                    if (e_pps && s_q.pps_have && e_vmin <= s_q.pps_vmin
                        && e_vmax >= s_q.pps_vmax && e_cur >= s_q.pps_cur) begin
                        s_d.pps_ok = 1'b1;
                    end
                    if (accept && better) begin
                        s_d.found = 1'b1;
                        s_d.best_idx = s_q.idx;
                        s_d.best_pwr = e_pwr;
                        s_d.best_rank = e_rank;
                        s_d.best_v = e_vmax;
                        s_d.best_cur = e_cur;
                    end
                end
                s_d.idx = s_q.idx + 1'b1;
                if (s_q.idx == IDX_W'(N_PDO - 1)) begin
                    s_d.st = sap_pkg::S_DONE;
                    s_d.mism = !s_d.thr_hit || (cfg_q[sap_pkg::CFG_PPS_EN] && !s_d.pps_ok);
                    s_d.flag = s_d.mism && !cfg_q[sap_pkg::CFG_SUPPRESS];
                end
            end
            sap_pkg::S_DONE: begin
                s_d.st = sap_pkg::S_IDLE;
                s_d.rdo_valid = 1'b1;
                s_d.rdo = 32'h0000_0000;
                s_d.rdo[sap_pkg::RDO_POS_LO +: 3] = s_q.found ? 3'(s_q.best_idx + 1'b1) : 3'h1;
                s_d.rdo[sap_pkg::RDO_MISMATCH] = s_q.flag;
                s_d.rdo[sap_pkg::RDO_NO_SUSP] = cfg_q[sap_pkg::CFG_NO_SUSP];
                s_d.rdo[sap_pkg::RDO_OP_LO +: 10] = s_q.best_cur;
                s_d.rdo[sap_pkg::RDO_MAX_LO +: 10] = s_q.best_cur;
            end
        endcase
        // new events are never lost to a clear in the same cycle
        s_d.snk_pend = s_d.snk_pend || snk_caps_wr_i || cfg_wr_i;
        s_d.src_pend = s_d.src_pend || src_caps_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sink path: vetoed by a flagged contract, restored by the ready task

    always_comb begin
        path_d = path_q;
        if (s_q.st == sap_pkg::S_DONE && cfg_q[sap_pkg::CFG_AUTO_DIS]) begin
            path_d = !s_q.flag;
        end
        if (sink_ready_task_i) begin
            path_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            path_q <= sap_pkg::PATH_RST;
        end else begin
            path_q <= path_d;
        end
    end

    // output mapping
    assign busy_o = (s_q.st != sap_pkg::S_IDLE) || s_q.snk_pend || s_q.src_pend;
    assign rdo_valid_o = s_q.rdo_valid;
    assign rdo_o = s_q.rdo;
    assign cap_mismatch_o = s_q.mism;
    assign sink_path_en_o = path_q;
    assign sink_required_power_o = s_q.req_pwr;
    assign neg_voltage_ceiling_o = ceil_q;
    assign neg_voltage_floor_o = floor_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_path_off_flag: assert property ((s_q.st == sap_pkg::S_DONE && s_q.flag
        && cfg_q[sap_pkg::CFG_AUTO_DIS] && !sink_ready_task_i) |=> !sink_path_en_o)
        else $error("sink path stayed on after flagged contract");
    a_ready_on: assert property (sink_ready_task_i |=> sink_path_en_o)
        else $error("ready task did not enable sink path");
    a_redisable_rdo: assert property ((rdo_valid_o && rdo_o[sap_pkg::RDO_MISMATCH]
        && $past(cfg_q[sap_pkg::CFG_AUTO_DIS]) && !$past(sink_ready_task_i)) |-> !sink_path_en_o)
        else $error("flagged request left sink path on");
    a_ceil_source: assert property (1'b1 |=> neg_voltage_ceiling_o ==
        ($past(cfg_q[sap_pkg::CFG_AUTO_CEIL]) ? $past(s_q.auto_ceil) : $past(neg_voltage_ceiling_i)))
        else $error("voltage ceiling from wrong source");
    a_floor_source: assert property (1'b1 |=> neg_voltage_floor_o ==
        ($past(cfg_q[sap_pkg::CFG_AUTO_FLOOR]) ? $past(s_q.auto_floor) : $past(neg_voltage_floor_i)))
        else $error("voltage floor from wrong source");
    a_cfg_reset: assert property (!$past(rst_n_i) |-> cfg_q == sap_pkg::CFG_RST)
        else $error("configuration reset image wrong");
    a_thr_hit: assert property ((s_q.st == sap_pkg::S_SRC && in_rng
        && e_pwr >= {2'h0, mismatch_power_threshold_i}) |=> s_q.thr_hit
        && (s_q.st != sap_pkg::S_DONE || !s_q.mism || $past(cfg_q[sap_pkg::CFG_PPS_EN])))
        else $error("threshold object not recorded");
    a_flag_gate: assert property (rdo_valid_o |->
        (rdo_o[sap_pkg::RDO_MISMATCH] == s_q.flag) && (!s_q.flag || cap_mismatch_o))
        else $error("mismatch flag not tied to condition");
    a_req_all: assert property ((s_q.st == sap_pkg::S_SNK && in_rng)
        |=> s_q.all_max >= $past(e_pwr))
        else $error("sink maximum power not tracked");
    a_req_batt: assert property ((s_q.st == sap_pkg::S_SNK && in_rng
        && e_kind == sap_pkg::PDO_BATT) |=> s_q.have_bat && s_q.bat_max >= $past(e_pwr))
        else $error("battery power not tracked");
    a_nosusp_copy: assert property (s_q.st == sap_pkg::S_DONE |=> rdo_valid_o
        && rdo_o[sap_pkg::RDO_NO_SUSP] == $past(cfg_q[sap_pkg::CFG_NO_SUSP]))
        else $error("no-suspend flag not copied");
    a_sel_ceiling: assert property ((s_q.st == sap_pkg::S_SRC && in_rng
        && e_vmax > ceil_q) |=> !(s_q.found && s_q.best_idx == $past(s_q.idx)))
        else $error("object above ceiling selected");
    a_pick_power: assert property ((s_q.st == sap_pkg::S_SRC && in_rng && accept
        && e_pwr > s_q.best_pwr) |=> s_q.best_pwr == $past(e_pwr))
        else $error("higher power object not taken");
endmodule : sap_sink_policy

// File: dv/sap_source_model.sv
// attached source port model: offers capabilities and collects the request
`timescale 1ns/1ps
module sap_source_model (
    input wire logic clk_i,
    input wire logic rdo_valid_i,
    input wire logic [31:0] rdo_i,
    output logic src_caps_o,
    output logic [223:0] src_caps_pdo_o,
    output logic [2:0] src_count_o
);
    initial begin
        src_caps_o = 1'b0;
        src_caps_pdo_o = '1;
        src_count_o = 3'h0;
    end
    // one offer: pulse, hold the objects until the request comes back
    task automatic offer(input logic [223:0] p, input logic [2:0] n,
                         output logic [31:0] rdo, output logic ok);
        int k;
        @(posedge clk_i); #1;
        src_caps_pdo_o = p;
        src_count_o = n;
        src_caps_o = 1'b1;
        @(posedge clk_i); #1;
        src_caps_o = 1'b0;
        k = 0;
        while (rdo_valid_i !== 1'b1 && k < 40) begin
            @(posedge clk_i); #1;
            k++;
        end
        ok = (k < 40);
        rdo = rdo_i;
        src_caps_pdo_o = ~p; // released lines no longer show the offer
    endtask : offer
endmodule : sap_source_model

// File: dv/sap_sink_policy_test.sv
// self-checking bench for the sink policy block
`timescale 1ns/1ps
module sap_sink_policy_test;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_wr_i = 1'b0;
    logic snk_caps_wr_i = 1'b0;
    logic sink_ready_task_i = 1'b0;
    logic [6:0] cfg = 7'h36;
    logic [9:0] ceil_i = 10'h000, floor_i = 10'h000, thr_i = 10'h01E;
    logic [223:0] snk_caps = '0;
    logic [2:0] snk_cnt = 3'h0;
    logic src_caps_i, busy_o, rdo_valid_o, cap_mismatch_o, sink_path_en_o, ok;
    logic [223:0] src_caps_pdo_i;
    logic [2:0] src_count_i;
    logic [31:0] rdo_o, rdo;
    logic [9:0] sink_required_power_o, neg_voltage_ceiling_o, neg_voltage_floor_o;
    int num_errors = 0;
    int samples_checked = 0;
    always #5 clk_i = ~clk_i;
    sap_sink_policy #(.N_PDO(7), .CNT_W(3)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
        .cfg_auto_disable_i(cfg[6]), .cfg_auto_ceiling_i(cfg[5]),
        .cfg_auto_floor_select_i(cfg[4]), .cfg_pps_enable_i(cfg[3]),
        .cfg_suppress_cap_mismatch_i(cfg[2]), .cfg_no_suspend_flag_i(cfg[1]),
        .cfg_tie_lower_i(cfg[0]), .neg_voltage_ceiling_i(ceil_i),
        .neg_voltage_floor_i(floor_i), .mismatch_power_threshold_i(thr_i),
        .snk_caps_wr_i(snk_caps_wr_i), .transmit_sink_capabilities_i(snk_caps),
        .snk_count_i(snk_cnt), .src_caps_i(src_caps_i), .src_caps_pdo_i(src_caps_pdo_i),
        .src_count_i(src_count_i), .sink_ready_task_i(sink_ready_task_i),
        .busy_o(busy_o), .rdo_valid_o(rdo_valid_o), .rdo_o(rdo_o),
        .cap_mismatch_o(cap_mismatch_o), .sink_path_en_o(sink_path_en_o),
        .sink_required_power_o(sink_required_power_o),
        .neg_voltage_ceiling_o(neg_voltage_ceiling_o),
        .neg_voltage_floor_o(neg_voltage_floor_o)
    );
    sap_source_model src (
        .clk_i(clk_i), .rdo_valid_i(rdo_valid_o), .rdo_i(rdo_o), .src_caps_o(src_caps_i),
        .src_caps_pdo_o(src_caps_pdo_i), .src_count_o(src_count_i)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // object builders and expected request image
    function automatic logic [31:0] fx(input logic [9:0] v, input logic [9:0] i);
        return {2'h0, 10'h000, v, i};
    endfunction : fx
    function automatic logic [31:0] bt(input logic [9:0] vx, input logic [9:0] vn,
                                       input logic [9:0] p);
        return {2'h1, vx, vn, p};
    endfunction : bt
    function automatic logic [31:0] rq(input logic [2:0] pos, input logic mm, input logic ns,
                                       input logic [9:0] cur);
        return {1'b0, pos, 1'b0, mm, 1'b0, ns, 4'h0, cur, cur};
    endfunction : rq
    ////////////////////////////////////////////////////////////////////////////////
    // closing report
    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // waits for the scan to end, then one cycle for the limit outputs
    task automatic idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 50) begin
            @(posedge clk_i); #1;
            n++;
        end
        if (n == 50) begin
            num_errors++;
            give_verdict();
        end
        @(posedge clk_i); #1;
    endtask : idle
    task automatic wr_cfg(input logic [6:0] c);
        @(posedge clk_i); #1;
        cfg = c;
        cfg_wr_i = 1'b1;
        @(posedge clk_i); #1;
        cfg_wr_i = 1'b0;
        idle();
    endtask : wr_cfg
    task automatic wr_snk(input logic [2:0] n);
        @(posedge clk_i); #1;
        snk_cnt = n;
        snk_caps_wr_i = 1'b1;
        @(posedge clk_i); #1;
        snk_caps_wr_i = 1'b0;
        idle();
    endtask : wr_snk
    task automatic ofr(input logic [223:0] p, input logic [2:0] n);
        src.offer(p, n, rdo, ok);
        if (!ok) begin
            num_errors++;
            give_verdict();
        end
    endtask : ofr
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        chk(sink_path_en_o, 1); chk(rdo_o, 0); chk(busy_o, 0);
        snk_caps[95:0] = {bt(10'd200, 10'd100, 10'd40), fx(10'd180, 10'd200), fx(10'd100, 10'd300)};
        wr_snk(3'h2);
        chk(sink_required_power_o, 72);
        chk(neg_voltage_ceiling_o, 180);
        chk(neg_voltage_floor_o, 100);
        wr_cfg(7'h72);
        ofr({192'h0, fx(10'd100, 10'd100)}, 3'h1);
        chk(rdo, rq(3'h1, 1'b1, 1'b1, 10'd100));
        chk(cap_mismatch_o, 1); chk(sink_path_en_o, 0);
        @(posedge clk_i); #1 sink_ready_task_i = 1'b1;
        @(posedge clk_i); #1 sink_ready_task_i = 1'b0;
        chk(sink_path_en_o, 1);
        ofr({192'h0, fx(10'd100, 10'd100)}, 3'h1);
        chk(sink_path_en_o, 0);
        ofr({160'h0, fx(10'd180, 10'd300), fx(10'd100, 10'd300)}, 3'h2);
        chk(rdo, rq(3'h2, 1'b0, 1'b1, 10'd300)); chk(cap_mismatch_o, 0);
        ofr({160'h0, fx(10'd150, 10'd200), fx(10'd100, 10'd300)}, 3'h2);
        chk(rdo, rq(3'h2, 1'b0, 1'b1, 10'd200));
        wr_cfg(7'h73);
        ofr({160'h0, fx(10'd150, 10'd200), fx(10'd100, 10'd300)}, 3'h2);
        chk(rdo, rq(3'h1, 1'b0, 1'b1, 10'd300));
        ceil_i = 10'd120;
        floor_i = 10'd90;
        wr_cfg(7'h52);
        chk(neg_voltage_ceiling_o, 120); chk(neg_voltage_floor_o, 100);
        ofr({160'h0, fx(10'd150, 10'd400), fx(10'd100, 10'd300)}, 3'h2);
        chk(rdo, rq(3'h1, 1'b0, 1'b1, 10'd300));
        wr_cfg(7'h04);
        chk(neg_voltage_floor_o, 90);
        ofr({192'h0, fx(10'd100, 10'd100)}, 3'h1);
        chk(rdo, rq(3'h1, 1'b0, 1'b0, 10'd100)); chk(cap_mismatch_o, 1);
        // variable object priced at its max voltage beats the fixed one
        ofr({160'h0, 2'h2, 10'd110, 10'd95, 10'd300, fx(10'd100, 10'd300)}, 3'h2);
        chk(rdo, rq(3'h2, 1'b0, 1'b0, 10'd300));
        wr_snk(3'h3);
        chk(sink_required_power_o, 40);
        wr_cfg(7'h4A);
        ofr({192'h0, fx(10'd100, 10'd300)}, 3'h1);
        chk(rdo, rq(3'h1, 1'b1, 1'b1, 10'd300)); chk(sink_path_en_o, 0);
        // sink programmable need met by a source programmable object
        snk_caps[127:96] = {2'h3, 2'h0, 3'h0, 8'd50, 1'b0, 8'd40, 1'b0, 7'd20};
        wr_snk(3'h4);
        ofr({160'h0, 2'h3, 2'h0, 3'h0, 8'd60, 1'b0, 8'd30, 1'b0, 7'd40,
             fx(10'd100, 10'd300)}, 3'h2);
        chk(rdo, rq(3'h1, 1'b0, 1'b1, 10'd300)); chk(cap_mismatch_o, 0);
        chk(sink_path_en_o, 1);
        give_verdict();
    end
endmodule : sap_sink_policy_test
